/* File: hw/hcr_map.svh */
`ifndef HCR_MAP_SVH
`define HCR_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define HCR_OFS_DEVCFG 8'h05
`define HCR_OFS_CHARGE 8'h06

// ****************************************************************
// field positions
// ****************************************************************
`define HCR_DEV_MSB 5
`define HCR_DEV_LSB 2
`define HCR_BIT_LPDIS 5
`define HCR_BIT_IND 4
`define HCR_BIT_GANG 3
`define HCR_BIT_PM 2
`define HCR_CHG_MSB 3
`define HCR_CHG_LSB 0

// ****************************************************************
// reset and fixed values
// ****************************************************************
`define HCR_RST_DEV 4'h0
`define HCR_RST_CHG 4'h0
`define HCR_RST_BYTE 8'h00
`define HCR_FIXED_ONE 1'b1
`define HCR_RSVD_DEV 2'h0
`define HCR_RSVD_CHG 4'h0

`endif

/* File: hw/hcr_pkg.sv */
package hcr_pkg;

    // ************************************************************
    // modes and carriers
    // ************************************************************
    typedef enum logic [0:0] {
        HCR_MODE_I2C = 1'b0,
        HCR_MODE_SMBUS = 1'b1
    } hcr_mode_t;

    typedef struct packed {
        logic lp_disable;
        logic indicator;
        logic ganged;
        logic full_pm;
    } hcr_devcfg_t;

    typedef struct packed {
        hcr_devcfg_t dev;
        logic [3:0] charge;
    } hcr_strap_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hcr_wr_t;

endpackage : hcr_pkg

/* File: hw/hcr_strap_capture.sv */
`timescale 1ns/1ps
`include "hcr_map.svh"

module hcr_strap_capture import hcr_pkg::*; (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic variant_strapped_i,
    input wire logic serial_data_strap_pin_i,
    input wire logic indicator_addr3_strap_pin_i,
    input wire logic gang_addr2_strap_pin_i,
    input wire logic powermgmt_addr1_strap_pin_i,
    input wire logic [3:0] per_port_power_charge_straps_i,
    output logic cap_en_o,
    output logic variant_o,
    output hcr_strap_t strap_o
);

    typedef enum logic [0:0] {
        ST_CAPTURE = 1'b0,
        ST_RUN = 1'b1
    } hcr_cap_st_t;

    hcr_cap_st_t st_reg;
    logic variant_reg;
    logic port0_power_charge_strap;

    // ************************************************************
    // one capture cycle right after reset release
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            st_reg <= ST_CAPTURE;
        end else begin
            st_reg <= ST_RUN;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            variant_reg <= 1'b0;
        end else if (st_reg == ST_CAPTURE) begin
            variant_reg <= variant_strapped_i;
        end
    end

    assign cap_en_o = (st_reg == ST_CAPTURE);
    assign variant_o = variant_reg;
    assign port0_power_charge_strap = per_port_power_charge_straps_i[0];

    // ************************************************************
    // strap values as the package variant maps them
    // ************************************************************
    always_comb begin
        strap_o.dev.lp_disable = serial_data_strap_pin_i;
        strap_o.dev.full_pm = powermgmt_addr1_strap_pin_i;
        if (variant_strapped_i) begin
            strap_o.dev.indicator = indicator_addr3_strap_pin_i;
            strap_o.dev.ganged = gang_addr2_strap_pin_i;
            strap_o.charge = per_port_power_charge_straps_i;
        end else begin
            strap_o.dev.indicator = `HCR_FIXED_ONE;
            strap_o.dev.ganged = `HCR_FIXED_ONE;
            strap_o.charge = {4{port0_power_charge_strap}};
        end
    end

endmodule : hcr_strap_capture

/* File: hw/hcr_linkpm_gate.sv */
`timescale 1ns/1ps

module hcr_linkpm_gate (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic lp_disable_i,
    input wire logic forced_linkpm_sent_i,
    input wire logic forced_linkpm_rcvd_i,
    input wire logic upstream_disconnect_i,
    output logic forced_o,
    output logic allowed_o
);

    logic forced_reg;
    logic allowed_reg;
    logic force_evt;

    assign force_evt = forced_linkpm_sent_i | forced_linkpm_rcvd_i;

    // ************************************************************
    // forced accept latch
    // ************************************************************
    // only power-on reset or upstream disconnect drops it; a force
    // arriving with a disconnect still wins so it is never lost
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            forced_reg <= 1'b0;
        end else if (force_evt) begin
            forced_reg <= 1'b1;
        end else if (upstream_disconnect_i) begin
            forced_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            allowed_reg <= 1'b0;
        end else begin
            allowed_reg <= !lp_disable_i | forced_reg | force_evt;
        end
    end

    assign forced_o = forced_reg;
    assign allowed_o = allowed_reg;

endmodule : hcr_linkpm_gate

/* File: hw/hcr_config_regs.sv */
`timescale 1ns/1ps
`include "hcr_map.svh"

module hcr_config_regs import hcr_pkg::*; (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire hcr_mode_t mode_i,
    input wire logic variant_strapped_i,
    input wire logic serial_data_strap_pin_i,
    input wire logic indicator_addr3_strap_pin_i,
    input wire logic gang_addr2_strap_pin_i,
    input wire logic powermgmt_addr1_strap_pin_i,
    input wire logic [3:0] per_port_power_charge_straps_i,
    input wire logic [3:0] port_used_i,
    input wire logic eeprom_wr_i,
    input wire hcr_wr_t eeprom_wr_data_i,
    input wire logic smbus_wr_i,
    input wire hcr_wr_t smbus_wr_data_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic forced_linkpm_sent_i,
    input wire logic forced_linkpm_rcvd_i,
    input wire logic upstream_disconnect_i,
    output logic [7:0] rd_data_o,
    output logic link_lowpower_disable_o,
    output logic port_indicator_support_o,
    output logic ganged_power_o,
    output logic full_power_management_o,
    output logic [3:0] charge_port_enable_o,
    output logic lowpower_allowed_o,
    output logic forced_accept_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [3:0] merge_bits(
        input logic [3:0] old_v,
        input logic [3:0] new_v,
        input logic [3:0] mask
    );
        merge_bits = (old_v & ~mask) | (new_v & mask);
    endfunction : merge_bits

    // ************************************************************
    // declarations
    // ************************************************************
    hcr_devcfg_t dev_reg;
    logic [3:0] chg_reg;
    logic [7:0] rd_data_reg;
    hcr_strap_t strap_w;
    logic cap_en_w;
    logic variant_w;
    logic forced_w;
    logic allowed_w;
    logic i2c_take_w;
    logic smb_take_w;
    logic wr_take_w;
    hcr_wr_t wr_w;
    logic dev_wr_w;
    logic chg_wr_w;
    logic [3:0] dev_mask_w;

    // ************************************************************
    // strap capture and link power gate
    // ************************************************************
    hcr_strap_capture u_strap (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .variant_strapped_i(variant_strapped_i),
        .serial_data_strap_pin_i(serial_data_strap_pin_i),
        .indicator_addr3_strap_pin_i(indicator_addr3_strap_pin_i),
        .gang_addr2_strap_pin_i(gang_addr2_strap_pin_i),
        .powermgmt_addr1_strap_pin_i(powermgmt_addr1_strap_pin_i),
        .per_port_power_charge_straps_i(per_port_power_charge_straps_i),
        .cap_en_o(cap_en_w),
        .variant_o(variant_w),
        .strap_o(strap_w)
    );

    hcr_linkpm_gate u_linkpm (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .lp_disable_i(dev_reg.lp_disable),
        .forced_linkpm_sent_i(forced_linkpm_sent_i),
        .forced_linkpm_rcvd_i(forced_linkpm_rcvd_i),
        .upstream_disconnect_i(upstream_disconnect_i),
        .forced_o(forced_w),
        .allowed_o(allowed_w)
    );

    // ************************************************************
    // write source selection
    // ************************************************************
    // the mode picks the only legal writer; writes in the capture
    // cycle are dropped so the strap values always land first
    assign i2c_take_w = (mode_i == HCR_MODE_I2C) & eeprom_wr_i;
    assign smb_take_w = (mode_i == HCR_MODE_SMBUS) & smbus_wr_i;
    assign wr_take_w = !cap_en_w & (i2c_take_w | smb_take_w);
    assign wr_w = i2c_take_w ? eeprom_wr_data_i : smbus_wr_data_i;
    assign dev_wr_w = wr_take_w & (wr_w.addr == `HCR_OFS_DEVCFG);
    assign chg_wr_w = wr_take_w & (wr_w.addr == `HCR_OFS_CHARGE);

    // indicator and ganged are writable only on the strapped variant
    assign dev_mask_w = {1'b1, variant_w, variant_w, 1'b1};

    // ************************************************************
    // device configuration bits
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            dev_reg <= `HCR_RST_DEV;
        end else if (cap_en_w) begin
            dev_reg <= strap_w.dev;
        end else if (dev_wr_w) begin
            dev_reg <= merge_bits(dev_reg,
                wr_w.data[`HCR_DEV_MSB:`HCR_DEV_LSB],
                dev_mask_w);
        end
    end

    // ************************************************************
    // charging enable bits
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            chg_reg <= `HCR_RST_CHG;
        end else if (cap_en_w) begin
            chg_reg <= strap_w.charge;
        end else if (chg_wr_w) begin
            chg_reg <= merge_bits(chg_reg,
                wr_w.data[`HCR_CHG_MSB:`HCR_CHG_LSB],
                port_used_i);
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // unmapped offsets answer zero; upper bits of the device
    // configuration byte are not held here and read zero too
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rd_data_reg <= `HCR_RST_BYTE;
        end else if (rd_en_i) begin
            unique case (rd_addr_i)
                `HCR_OFS_DEVCFG: begin
                    rd_data_reg <= {2'h0, dev_reg, `HCR_RSVD_DEV};
                end
                `HCR_OFS_CHARGE: begin
                    rd_data_reg <= {`HCR_RSVD_CHG, chg_reg};
                end
                default: begin
                    rd_data_reg <= `HCR_RST_BYTE;
                end
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data_o = rd_data_reg;
    assign link_lowpower_disable_o = dev_reg.lp_disable;
    assign port_indicator_support_o = dev_reg.indicator;
    assign ganged_power_o = dev_reg.ganged;
    assign full_power_management_o = dev_reg.full_pm;
    assign charge_port_enable_o = chg_reg;
    assign lowpower_allowed_o = allowed_w;
    assign forced_accept_o = forced_w;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_i2c_dev_load;
        !cap_en_w && mode_i == HCR_MODE_I2C && eeprom_wr_i &&
            eeprom_wr_data_i.addr == `HCR_OFS_DEVCFG;
    endsequence

    sequence s_smb_dev_write;
        !cap_en_w && mode_i == HCR_MODE_SMBUS && smbus_wr_i &&
            smbus_wr_data_i.addr == `HCR_OFS_DEVCFG;
    endsequence

    sequence s_forced_seen;
        (forced_linkpm_sent_i || forced_linkpm_rcvd_i) ##1 forced_w;
    endsequence

    sequence s_i2c_chg_load;
        !cap_en_w && mode_i == HCR_MODE_I2C && eeprom_wr_i &&
            eeprom_wr_data_i.addr == `HCR_OFS_CHARGE;
    endsequence

    sequence s_smb_chg_write;
        !cap_en_w && mode_i == HCR_MODE_SMBUS && smbus_wr_i &&
            smbus_wr_data_i.addr == `HCR_OFS_CHARGE;
    endsequence

    a_lp_blocked: assert property (
        dev_reg.lp_disable && !forced_w && !forced_linkpm_sent_i &&
            !forced_linkpm_rcvd_i |=> !lowpower_allowed_o)
        else $error("low power allowed while disabled");

    a_forced_keeps: assert property (
        s_forced_seen ##0 !upstream_disconnect_i [*2]
            |=> forced_w && lowpower_allowed_o)
        else $error("forced accept did not hold");

    a_strap_lpdis: assert property (
        cap_en_w |=> dev_reg.lp_disable == $past(serial_data_strap_pin_i))
        else $error("disable bit not taken from strap");

    a_i2c_load: assert property (
        s_i2c_dev_load |=> dev_reg.lp_disable ==
            $past(eeprom_wr_data_i.data[`HCR_BIT_LPDIS]))
        else $error("eeprom load not applied");

    a_smb_write: assert property (
        s_smb_dev_write |=> dev_reg.full_pm ==
            $past(smbus_wr_data_i.data[`HCR_BIT_PM]))
        else $error("smbus write not applied");

    a_fixed_ones: assert property (
        !cap_en_w && !variant_w |-> dev_reg.indicator && dev_reg.ganged)
        else $error("fixed bits not one");

    a_ind_strap: assert property (
        cap_en_w && variant_strapped_i |=>
            dev_reg.indicator == $past(indicator_addr3_strap_pin_i))
        else $error("indicator bit not taken from strap");

    a_gang_strap: assert property (
        cap_en_w && variant_strapped_i |=>
            dev_reg.ganged == $past(gang_addr2_strap_pin_i))
        else $error("ganged bit not taken from strap");

    a_pm_strap: assert property (
        cap_en_w |=> dev_reg.full_pm == $past(powermgmt_addr1_strap_pin_i))
        else $error("power management bit not taken from strap");

    a_dev_rsvd: assert property (
        rd_en_i && rd_addr_i == `HCR_OFS_DEVCFG |=>
            rd_data_o[1:0] == 2'h0 &&
            rd_data_o[`HCR_DEV_MSB:`HCR_DEV_LSB] == $past(dev_reg))
        else $error("device configuration read wrong");

    a_chg_rsvd: assert property (
        rd_en_i && rd_addr_i == `HCR_OFS_CHARGE |=>
            rd_data_o == {4'h0, $past(chg_reg)})
        else $error("charging read wrong");

    a_chg_masked: assert property (
        chg_wr_w |=> (chg_reg & ~$past(port_used_i)) ==
            ($past(chg_reg) & ~$past(port_used_i)))
        else $error("unused port charging bit changed");

    a_chg_single: assert property (
        cap_en_w && !variant_strapped_i |=>
            chg_reg == {4{$past(per_port_power_charge_straps_i[0])}})
        else $error("single strap not spread");

    a_chg_perport: assert property (
        cap_en_w && variant_strapped_i |=>
            chg_reg == $past(per_port_power_charge_straps_i))
        else $error("per port straps not taken");

    a_hold_idle: assert property (
        !cap_en_w && !wr_take_w |=> $stable(dev_reg) && $stable(chg_reg))
        else $error("configuration changed without cause");

    a_lp_open: assert property (
        !dev_reg.lp_disable |=> lowpower_allowed_o)
        else $error("low power blocked while enabled");

    a_gate_drop: assert property (
        forced_w && upstream_disconnect_i && !forced_linkpm_sent_i &&
            !forced_linkpm_rcvd_i |=> !forced_w)
        else $error("forced accept survived disconnect");

    a_wrong_writer: assert property (
        !cap_en_w && mode_i == HCR_MODE_I2C && smbus_wr_i && !eeprom_wr_i
            |=> $stable(dev_reg) && $stable(chg_reg))
        else $error("smbus write taken in eeprom mode");

    a_i2c_chg: assert property (
        s_i2c_chg_load |=> (chg_reg & $past(port_used_i)) ==
            ($past(eeprom_wr_data_i.data[`HCR_CHG_MSB:`HCR_CHG_LSB]) &
            $past(port_used_i)))
        else $error("eeprom charging load not applied");

    a_smb_chg: assert property (
        s_smb_chg_write |=> (chg_reg & $past(port_used_i)) ==
            ($past(smbus_wr_data_i.data[`HCR_CHG_MSB:`HCR_CHG_LSB]) &
            $past(port_used_i)))
        else $error("smbus charging write not applied");

endmodule : hcr_config_regs

/* File: tb/hcr_writer_model.sv */
`timescale 1ns/1ps

module hcr_writer_model import hcr_pkg::*; (
    input wire logic clock_i,
    input wire logic req_i,
    input wire logic to_smbus_i,
    input wire hcr_wr_t req_data_i,
    output logic eeprom_wr_o,
    output hcr_wr_t eeprom_wr_data_o,
    output logic smbus_wr_o,
    output hcr_wr_t smbus_wr_data_o
);
    // ************************************************************
    // one byte per strobe; idle data lines toggle so stale bytes
    // can never look like a valid write
    // ************************************************************
    initial begin
        eeprom_wr_o = 1'b0;
        smbus_wr_o = 1'b0;
        eeprom_wr_data_o = 16'h0000;
        smbus_wr_data_o = 16'h0000;
        forever begin
            @(posedge clock_i);
            eeprom_wr_o <= req_i && !to_smbus_i;
            smbus_wr_o <= req_i && to_smbus_i;
            eeprom_wr_data_o <= (req_i && !to_smbus_i) ? req_data_i
                                                        : ~eeprom_wr_data_o;
            smbus_wr_data_o <= (req_i && to_smbus_i) ? req_data_i
                                                      : ~smbus_wr_data_o;
        end
    end
endmodule : hcr_writer_model

/* File: tb/tb_hcr_config_regs.sv */
`timescale 1ns/1ps

module tb_hcr_config_regs import hcr_pkg::*;;
    logic clock_i, nrst_i, variant, sd, ind, gang, pm, req, to_smb;
    logic rd_en, fs, fr, disc, rd_pend, ew, sw;
    logic [3:0] pp, used, chg_o;
    logic [7:0] rd_addr, rd_data;
    hcr_mode_t mode;
    hcr_wr_t req_data, ewd, swd;
    logic lp_o, ind_o, gang_o, pm_o, allow_o, forced_o;
    logic e_lp, e_ind, e_gang, e_pm;
    logic [3:0] e_chg;
    logic [7:0] q[$];
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    hcr_writer_model partner (.clock_i(clock_i), .req_i(req),
        .to_smbus_i(to_smb), .req_data_i(req_data), .eeprom_wr_o(ew),
        .eeprom_wr_data_o(ewd), .smbus_wr_o(sw), .smbus_wr_data_o(swd));

    hcr_config_regs dut (.clock_i(clock_i), .nrst_i(nrst_i), .mode_i(mode),
        .variant_strapped_i(variant), .serial_data_strap_pin_i(sd),
        .indicator_addr3_strap_pin_i(ind), .gang_addr2_strap_pin_i(gang),
        .powermgmt_addr1_strap_pin_i(pm),
        .per_port_power_charge_straps_i(pp), .port_used_i(used),
        .eeprom_wr_i(ew), .eeprom_wr_data_i(ewd), .smbus_wr_i(sw),
        .smbus_wr_data_i(swd), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .forced_linkpm_sent_i(fs), .forced_linkpm_rcvd_i(fr),
        .upstream_disconnect_i(disc), .rd_data_o(rd_data),
        .link_lowpower_disable_o(lp_o), .port_indicator_support_o(ind_o),
        .ganged_power_o(gang_o), .full_power_management_o(pm_o),
        .charge_port_enable_o(chg_o), .lowpower_allowed_o(allow_o),
        .forced_accept_o(forced_o));

    // ************************************************************
    // clock, scoreboard and watchdog
    // ************************************************************
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // read data lands on the same edge that takes the request
    always @(posedge clock_i) rd_pend <= rd_en;
    always @(negedge clock_i) begin
        if (rd_pend === 1'b1) begin
            if (q.size() == 0)
                chk("read queue", 8'h00, 8'hFF);
            else
                chk("read data", q.pop_front(), rd_data);
        end
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            $display("watchdog expired");
            wrap_up();
        end
    end

    // ************************************************************
    // drivers
    // ************************************************************
    function automatic logic [7:0] exp_byte(logic [7:0] a);
        if (a == 8'h05)
            return {2'h0, e_lp, e_ind, e_gang, e_pm, 2'h0};
        if (a == 8'h06)
            return {4'h0, e_chg};
        return 8'h00;
    endfunction : exp_byte

    task automatic idle(int n);
        req = 1'b0;
        rd_en = 1'b0;
        {fs, fr, disc} = 3'h0;
        repeat (n) @(posedge clock_i) #1;
    endtask : idle

    task automatic rd(logic [7:0] a);
        rd_en = 1'b1;
        rd_addr = a;
        q.push_back(exp_byte(a));
        @(posedge clock_i) #1;
    endtask : rd

    task automatic wr(logic smb, logic [7:0] a, logic [7:0] d);
        req = 1'b1;
        to_smb = smb;
        req_data = {a, d};
        if (smb == logic'(mode) && a == 8'h05) begin
            e_lp = d[5];
            e_pm = d[2];
            if (variant) {e_ind, e_gang} = d[4:3];
        end
        if (smb == logic'(mode) && a == 8'h06)
            e_chg = (e_chg & ~used) | (d[3:0] & used);
        @(posedge clock_i) #1;
    endtask : wr

    task automatic chk_outs();
        chk("outputs", {e_lp, e_ind, e_gang, e_pm, e_chg},
            {lp_o, ind_o, gang_o, pm_o, chg_o});
    endtask : chk_outs

    task automatic do_reset(logic v);
        nrst_i = 1'b0;
        variant = v;
        {sd, ind, gang, pm, pp} = 8'($urandom);
        repeat (5) @(posedge clock_i) #1;
        chk("reset outputs", 8'h00, {lp_o, ind_o, gang_o, pm_o, chg_o});
        e_lp = sd;
        e_ind = v ? ind : 1'b1;
        e_gang = v ? gang : 1'b1;
        e_pm = pm;
        e_chg = v ? pp : {4{pp[0]}};
        nrst_i = 1'b1;
        repeat (2) @(posedge clock_i) #1;
        // straps moving after capture must not reach the registers
        {sd, ind, gang, pm, pp} = ~{sd, ind, gang, pm, pp};
        idle(2);
    endtask : do_reset

    task automatic pulse(logic s, logic r, logic d);
        {fs, fr, disc} = {s, r, d};
        @(posedge clock_i) #1;
        idle(3);
    endtask : pulse

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {nrst_i, variant, sd, ind, gang, pm, req, to_smb} = 8'h00;
        {rd_en, fs, fr, disc} = 4'h0;
        {pp, used, rd_addr} = 16'h0000;
        req_data = 16'h0000;
        mode = HCR_MODE_I2C;
        void'($urandom(48619));

        for (int v = 1; v >= 0; v--) begin
            do_reset(v[0]);
            chk_outs();
            rd(8'h05);
            rd(8'h06);
            rd(8'h07);
            rd(8'h00);
            idle(2);
        end
        $display("test strap capture done");

        for (int v = 0; v < 2; v++) begin
            do_reset(v[0]);
            for (int m = 0; m < 2; m++) begin
                mode = hcr_mode_t'(m);
                used = 4'($urandom);
                idle(2);
                for (int i = 0; i < 8; i++)
                    wr(i[2] ^ m[0], i[0] ? 8'h06 : 8'h05,
                       8'($urandom));
                // an unmapped offset must leave both registers alone
                wr(m[0], 8'h07, 8'($urandom));
                idle(2);
                chk_outs();
                rd(8'h05);
                rd(8'h06);
                idle(2);
            end
        end
        $display("test register writes done");

        mode = HCR_MODE_SMBUS;
        for (int k = 0; k < 2; k++) begin
            wr(1'b1, 8'h05, {2'h0, 1'b1, e_ind, e_gang, e_pm, 2'h0});
            idle(3);
            chk("gate idle", 8'h00, {6'h0, forced_o, allow_o});
            pulse(k == 0, k == 1, 1'b0);
            chk("gate forced", 8'h03, {6'h0, forced_o, allow_o});
            wr(1'b1, 8'h05, {2'h0, 1'b1, e_ind, e_gang, e_pm, 2'h0});
            idle(3);
            chk("gate held", 8'h03, {6'h0, forced_o, allow_o});
            pulse(1'b0, 1'b0, 1'b1);
            chk("gate dropped", 8'h00, {6'h0, forced_o, allow_o});
        end
        $display("test link power gate done");
        wrap_up();
    end
endmodule : tb_hcr_config_regs
